// ===== fspc_ctrl.sv
// Flash self-program controller: protected enable bit and trigger, operation sequencer, serial entry.
// Assumes a CPU register port with one-cycle write strobes, and a flash array port.
//
// Function
// - Operations need enable bit, set by protected write.
// - Block changes need its update enable set.
// - Address from high/low, data and command registers.
// - Protected trigger write starts the operation.
// - CPU frozen during operation, sequencer drives pump for erase and program.
// - Erase and program timed by internal counter.
// - Page erase 5 ms, byte program 23.5 us.
// - On finish release CPU, clear trigger.
// - Fail flag in chip control shows outcome.
// - Blocks made of 128-byte pages, erase one page.
// - Erase, program, read from software; programmer only shifts the data byte.
// - Reset pin held switches in-circuit programming mode.
// - Serial data bits clocked by programmer clock.
`timescale 1ns/1ps
module fspc_ctrl
  import fspc_pkg::*;
#(
  parameter int unsigned ERASE_CYCLES = FSPC_ERASE_CYCLES,
  parameter int unsigned PROG_CYCLES = FSPC_PROG_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic ta_wr_i,
  input wire logic [7:0] ta_data_i,
  input wire logic chip_ctrl_wr_i,
  input wire logic [7:0] chip_ctrl_wdata_i,
  input wire logic blk_upd_wr_i,
  input wire logic [7:0] blk_upd_wdata_i,
  input wire logic addr_high_wr_i,
  input wire logic addr_low_wr_i,
  input wire logic data_wr_i,
  input wire logic cmd_wr_i,
  input wire logic trig_wr_i,
  input wire logic [7:0] wdata_i,
  input wire logic flash_ok_i,
  input wire logic [7:0] flash_rdata_i,
  input wire logic prog_reset_pin_i,
  input wire logic prog_serial_clock_i,
  input wire logic prog_serial_data_i,
  output logic [7:0] chip_control_reg_o,
  output logic [7:0] block_update_enable_reg_o,
  output logic [7:0] target_addr_high_o,
  output logic [7:0] target_addr_low_o,
  output logic [7:0] flash_data_reg_o,
  output logic [7:0] flash_command_reg_o,
  output logic [7:0] trigger_reg_o,
  output logic cpu_hold_o,
  output logic pump_en_o,
  output logic flash_erase_o,
  output logic flash_prog_o,
  output logic flash_read_o,
  output logic [15:0] flash_addr_o,
  output logic [7:0] flash_wdata_o,
  output logic in_circuit_programming_o,
  output logic prog_serial_data_o,
  output logic prog_serial_data_oe_n_o
);
  // ----------------------------------------------------------------
  // Protection and software registers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {FSPC_TA_IDLE, FSPC_TA_KEY, FSPC_TA_OPEN} fspc_ta_t;
  typedef enum logic [1:0] {FSPC_S_IDLE, FSPC_S_BUSY, FSPC_S_DONE} fspc_state_t;

  fspc_ta_t ta_r, ta_nxt;
  logic [1:0] ta_cnt_r, ta_cnt_nxt;
  logic enable_r, enable_nxt;
  logic fail_r, fail_nxt;
  logic [7:0] upd_r, upd_nxt;
  logic [15:0] addr_r, addr_nxt;
  logic [7:0] data_r, data_nxt;
  logic [7:0] cmd_r, cmd_nxt;
  logic go_r, go_nxt;
  fspc_state_t st_r, st_nxt;
  logic load;
  logic [19:0] load_count;
  logic timer_done;
  logic [1:0] blk_sel;
  logic blk_ok;
  logic is_erase;
  logic is_prog;
  logic is_read;
  logic [7:0] cmd_op;
  logic icp_r, icp_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic sck_q_r, sck_nxt;
  logic sdo_r, sdo_nxt;

  assign blk_sel = 2'((cmd_r & FSPC_CMD_BLK_MASK) >> FSPC_CMD_BLK_POS);
  // The block field is stripped before decoding, so every block shares one opcode.
  assign cmd_op = cmd_r & ~FSPC_CMD_BLK_MASK;
  assign blk_ok = upd_r[blk_sel] || is_read;
  assign is_erase = (cmd_op == FSPC_CMD_ERASE);
  assign is_prog = (cmd_op == FSPC_CMD_PROGRAM);
  assign is_read = (cmd_op == FSPC_CMD_READ);

  always_comb begin
    ta_nxt = ta_r;
    ta_cnt_nxt = ta_cnt_r;
    enable_nxt = enable_r;
    fail_nxt = fail_r;
    upd_nxt = upd_r;
    addr_nxt = addr_r;
    data_nxt = data_r;
    cmd_nxt = cmd_r;
    go_nxt = go_r;
    // The key opens a short window so a stray write cannot unlock it later.
    case (ta_r)
      FSPC_TA_IDLE: if (ta_wr_i && ta_data_i == FSPC_TA_KEY1) begin
        ta_nxt = FSPC_TA_KEY;
      end
      FSPC_TA_KEY: begin
        ta_nxt = (ta_wr_i && ta_data_i == FSPC_TA_KEY2) ? FSPC_TA_OPEN : FSPC_TA_IDLE;
        ta_cnt_nxt = FSPC_TA_WINDOW;
      end
      FSPC_TA_OPEN: begin
        ta_cnt_nxt = ta_cnt_r - 2'h1;
        if (chip_ctrl_wr_i || trig_wr_i || ta_cnt_r == 2'h1) begin
          ta_nxt = FSPC_TA_IDLE;
        end
      end
      default: ta_nxt = FSPC_TA_IDLE;
    endcase
    if (chip_ctrl_wr_i && ta_r == FSPC_TA_OPEN) begin
      enable_nxt = chip_ctrl_wdata_i[FSPC_ENABLE_BIT];
    end
    if (st_r == FSPC_S_IDLE) begin
      if (blk_upd_wr_i) upd_nxt = blk_upd_wdata_i;
      if (addr_high_wr_i) addr_nxt[15:8] = wdata_i;
      if (addr_low_wr_i) addr_nxt[7:0] = wdata_i;
      if (data_wr_i) data_nxt = wdata_i;
      if (cmd_wr_i) cmd_nxt = wdata_i;
      if (trig_wr_i && ta_r == FSPC_TA_OPEN && wdata_i[FSPC_TRIG_BIT]
          && enable_r && blk_ok) begin
        go_nxt = 1'b1;
      end
    end
    if (st_r == FSPC_S_DONE) begin
      go_nxt = 1'b0;
      fail_nxt = !flash_ok_i;
      if (is_read) data_nxt = flash_rdata_i;
    end
  end

  // ----------------------------------------------------------------
  // Operation sequencer
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    load = 1'b0;
    load_count = 20'(FSPC_READ_CYCLES);
    case (st_r)
      FSPC_S_IDLE: if (go_r) begin
        st_nxt = FSPC_S_BUSY;
        load = 1'b1;
        if (is_erase) load_count = 20'(ERASE_CYCLES);
        else if (is_prog) load_count = 20'(PROG_CYCLES);
      end
      FSPC_S_BUSY: if (timer_done) st_nxt = FSPC_S_DONE;
      FSPC_S_DONE: st_nxt = FSPC_S_IDLE;
      default: st_nxt = FSPC_S_IDLE;
    endcase
  end

  fspc_timer #(.WIDTH(20)) u_timer (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .load_i(load),
    .count_i(load_count),
    .done_o(timer_done)
  );

  // ----------------------------------------------------------------
  // Serial programming entry
  // ----------------------------------------------------------------
  // Pins are taken as synchronous; data is shifted on the programmer clock's rising edge.
  always_comb begin
    icp_nxt = !prog_reset_pin_i;
    sck_nxt = prog_serial_clock_i;
    sh_nxt = sh_r;
    sdo_nxt = sdo_r;
    // Outside the mode the shifter tracks the data register, so that byte goes out first.
    if (!icp_r) begin
      sh_nxt = data_r;
    end else if (prog_serial_clock_i && !sck_q_r) begin
      sh_nxt = {sh_r[6:0], prog_serial_data_i};
      sdo_nxt = sh_r[7];
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ta_r <= FSPC_TA_IDLE;
      ta_cnt_r <= 2'h0;
      enable_r <= 1'b0;
      fail_r <= 1'b0;
      upd_r <= 8'h00;
      addr_r <= 16'h0000;
      data_r <= 8'h00;
      cmd_r <= 8'h00;
      go_r <= 1'b0;
      st_r <= FSPC_S_IDLE;
      icp_r <= 1'b0;
      sh_r <= 8'h00;
      sck_q_r <= 1'b0;
      sdo_r <= 1'b0;
    end else begin
      ta_r <= ta_nxt;
      ta_cnt_r <= ta_cnt_nxt;
      enable_r <= enable_nxt;
      fail_r <= fail_nxt;
      upd_r <= upd_nxt;
      addr_r <= addr_nxt;
      data_r <= data_nxt;
      cmd_r <= cmd_nxt;
      go_r <= go_nxt;
      st_r <= st_nxt;
      icp_r <= icp_nxt;
      sh_r <= sh_nxt;
      sck_q_r <= sck_nxt;
      sdo_r <= sdo_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_comb begin
    chip_control_reg_o = FSPC_CHIP_CTRL_RST;
    chip_control_reg_o[FSPC_ENABLE_BIT] = enable_r;
    chip_control_reg_o[FSPC_FAIL_BIT] = fail_r;
    trigger_reg_o = 8'h00;
    trigger_reg_o[FSPC_TRIG_BIT] = go_r;
  end
  assign block_update_enable_reg_o = upd_r;
  assign target_addr_high_o = addr_r[15:8];
  assign target_addr_low_o = addr_r[7:0];
  assign flash_data_reg_o = data_r;
  assign flash_command_reg_o = cmd_r;
  assign cpu_hold_o = go_r;
  assign pump_en_o = (st_r == FSPC_S_BUSY) && (is_erase || is_prog);
  assign flash_erase_o = (st_r == FSPC_S_BUSY) && is_erase;
  assign flash_prog_o = (st_r == FSPC_S_BUSY) && is_prog;
  assign flash_read_o = (st_r == FSPC_S_BUSY) && is_read;
  // Erase addresses a whole page, so the offset inside the page is forced to zero.
  assign flash_addr_o = is_erase ? {addr_r[15:FSPC_PAGE_SHIFT], 7'h00} : addr_r;
  assign flash_wdata_o = data_r;
  assign in_circuit_programming_o = icp_r;
  assign prog_serial_data_o = sdo_r;
  assign prog_serial_data_oe_n_o = !icp_r;
endmodule

// ===== fspc_ctrl_props.sv
// Port checker for the flash self-program controller.
// Bound to every controller instance; sees only its ports.
`timescale 1ns/1ps
module fspc_ctrl_props #(
  parameter int unsigned ERASE_CYCLES = 1,
  parameter int unsigned PROG_CYCLES = 1
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic trig_wr_i,
  input wire logic [7:0] wdata_i,
  input wire logic flash_ok_i,
  input wire logic prog_reset_pin_i,
  input wire logic [7:0] chip_control_reg_o,
  input wire logic [7:0] target_addr_high_o,
  input wire logic [7:0] target_addr_low_o,
  input wire logic [7:0] flash_data_reg_o,
  input wire logic [7:0] trigger_reg_o,
  input wire logic cpu_hold_o,
  input wire logic pump_en_o,
  input wire logic flash_erase_o,
  input wire logic flash_prog_o,
  input wire logic [15:0] flash_addr_o,
  input wire logic [7:0] flash_wdata_o,
  input wire logic in_circuit_programming_o,
  input wire logic prog_serial_data_oe_n_o
);
  logic [19:0] run_r;
  logic [19:0] run_nxt;
  // Counts pump cycles so long timings need no unrolled repetition.
  always_comb run_nxt = pump_en_o ? run_r + 20'h1 : 20'h0;
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) run_r <= 20'h0;
    else run_r <= run_nxt;
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_done; $fell(pump_en_o); endsequence
  property p_refuse;
    trig_wr_i && wdata_i[0] && !chip_control_reg_o[0] && !trigger_reg_o[0]
      |=> !trigger_reg_o[0] [*2];
  endproperty
  a_refuse: assert property (p_refuse) else $error("trigger taken while disabled");
  property p_hold; $rose(cpu_hold_o) |-> $past(trig_wr_i) && $past(wdata_i[0]); endproperty
  a_hold: assert property (p_hold) else $error("cpu held without trigger");
  property p_pump; pump_en_o |-> cpu_hold_o; endproperty
  a_pump: assert property (p_pump) else $error("pump on while cpu runs");
  property p_page; flash_erase_o |-> flash_addr_o[6:0] == 7'h0; endproperty
  a_page: assert property (p_page) else $error("erase address not page aligned");
  property p_addr;
    flash_prog_o |-> flash_addr_o == {target_addr_high_o, target_addr_low_o}
      && flash_wdata_o == flash_data_reg_o;
  endproperty
  a_addr: assert property (p_addr) else $error("program address or data wrong");
  property p_erase_len; s_done ##0 $past(flash_erase_o) |-> run_r == ERASE_CYCLES + 1; endproperty
  a_erase_len: assert property (p_erase_len) else $error("erase length wrong");
  property p_prog_len; s_done ##0 $past(flash_prog_o) |-> run_r == PROG_CYCLES + 1; endproperty
  a_prog_len: assert property (p_prog_len) else $error("program length wrong");
  property p_clear; s_done |-> ##[1:2] !trigger_reg_o[0]; endproperty
  a_clear: assert property (p_clear) else $error("go not cleared");
  property p_fail; s_done |=> chip_control_reg_o[6] == !$past(flash_ok_i); endproperty
  a_fail: assert property (p_fail) else $error("fail flag wrong");
  property p_icp; !prog_reset_pin_i [*4] |-> in_circuit_programming_o; endproperty
  a_icp: assert property (p_icp) else $error("programming mode not entered");
  property p_oe; prog_reset_pin_i |=> prog_serial_data_oe_n_o; endproperty
  a_oe: assert property (p_oe) else $error("data pin driven outside mode");
endmodule
bind fspc_ctrl fspc_ctrl_props #(.ERASE_CYCLES(ERASE_CYCLES), .PROG_CYCLES(PROG_CYCLES)) i_props (.*);

// ===== fspc_ctrl_tb.sv
// Self-checking bench: controller, flash model and a byte-level reference.
// Assumes package, controller, checker and flash model compile first.
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin bad_count++; $display("[ERR] %0t got %h want %h", $time, a, b); end end
module fspc_ctrl_tb;
  import fspc_pkg::*;
  localparam int ER = 50;
  localparam int PR = 20;
  logic sys_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [7:0] str = 8'h0;
  logic [7:0] wv = 8'h0;
  logic fail = 1'b0;
  logic rpin = 1'b1;
  logic sck = 1'b0;
  logic sda = 1'b0;
  logic ok, er, pg, rd, in_circuit_programming, oe_n;
  logic [7:0] rdat, wdat, chip, trg, fdat;
  logic [15:0] fadr;
  logic hold, pump, sdo;
  logic [7:0] bue, cmdr, tah, tal;
  logic [31:0] seed = 32'h989ffd35;
  int bad_count = 0;
  int n_tests = 0;
  int hold_n = 0;
  int pump_n = 0;
  int mem [int];
  initial forever #5 sys_clk_i = ~sys_clk_i;
  fspc_ctrl #(.ERASE_CYCLES(ER), .PROG_CYCLES(PR)) i_dut (.sys_clk_i, .reset_n_i,
    .ta_wr_i(str[0]), .ta_data_i(wv), .chip_ctrl_wr_i(str[1]), .chip_ctrl_wdata_i(wv),
    .blk_upd_wr_i(str[2]), .blk_upd_wdata_i(wv), .addr_high_wr_i(str[3]),
    .addr_low_wr_i(str[4]), .data_wr_i(str[5]), .cmd_wr_i(str[6]), .trig_wr_i(str[7]),
    .wdata_i(wv), .flash_ok_i(ok), .flash_rdata_i(rdat), .prog_reset_pin_i(rpin),
    .prog_serial_clock_i(sck), .prog_serial_data_i(sda), .chip_control_reg_o(chip),
    .block_update_enable_reg_o(bue), .target_addr_high_o(tah), .target_addr_low_o(tal),
    .flash_data_reg_o(fdat), .flash_command_reg_o(cmdr), .trigger_reg_o(trg),
    .cpu_hold_o(hold), .pump_en_o(pump), .flash_erase_o(er), .flash_prog_o(pg),
    .flash_read_o(rd), .flash_addr_o(fadr), .flash_wdata_o(wdat),
    .in_circuit_programming_o(in_circuit_programming), .prog_serial_data_o(sdo), .prog_serial_data_oe_n_o(oe_n));
  fspc_flash_model i_flash (.sys_clk_i, .erase_i(er), .prog_i(pg), .read_i(rd),
    .addr_i(fadr), .wdata_i(wdat), .fail_i(fail), .ok_o(ok), .rdata_o(rdat));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] mdl(input int a);
    return mem.exists(a) ? mem[a][7:0] : 8'hff;
  endfunction
  task automatic test_done();
    $display("checks %0d errors %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Called at a falling edge; leaves the strobe up for one whole cycle.
  task automatic w(input int i, input logic [7:0] v);
    str = 8'h1 << i;
    wv = v;
    @(negedge sys_clk_i);
  endtask
  task automatic op(input logic [7:0] c, input logic [15:0] a, input bit t, output int n);
    int i;
    w(3, a[15:8]);
    w(4, a[7:0]);
    w(6, c);
    if (t) w(0, FSPC_TA_KEY1);
    if (t) w(0, FSPC_TA_KEY2);
    w(7, 8'h01);
    str = 8'h0;
    n = 0;
    i = 0;
    hold_n = 0;
    pump_n = 0;
    while (i < 700 && (n == 0 || trg[0] !== 1'b0)) begin
      if (trg[0] === 1'b1) n++;
      if (hold === 1'b1) hold_n++;
      if (pump === 1'b1) pump_n++;
      i++;
      @(negedge sys_clk_i);
    end
    if (trg[0] !== 1'b0) begin
      bad_count++;
      test_done();
    end
  endtask
  initial begin
    int n;
    logic [15:0] a;
    logic [7:0] d;
    logic b;
    logic [31:0] v;
    logic q [$];
    repeat (16) @(negedge sys_clk_i);
    reset_n_i = 1'b1;
    `CHK(chip, FSPC_CHIP_CTRL_RST)
    `CHK(oe_n, 1'b1)
    w(1, 8'h01);
    op(FSPC_CMD_ERASE, 16'h0, 1, n);
    `CHK(n, 0)
    `CHK(chip[0], 1'b0)
    w(0, FSPC_TA_KEY1);
    w(0, FSPC_TA_KEY2);
    w(1, 8'h01);
    w(2, 8'h01);
    `CHK(chip[0], 1'b1)
    `CHK(bue, 8'h01)
    op(FSPC_CMD_PROGRAM | 8'h04, 16'h4000, 1, n);
    `CHK(n, 0)
    op(FSPC_CMD_ERASE, 16'h0, 0, n);
    `CHK(n, 0)
    // Three plain writes after the keys use up the window, so the trigger is late.
    w(0, FSPC_TA_KEY1);
    w(0, FSPC_TA_KEY2);
    op(FSPC_CMD_ERASE, 16'h0, 0, n);
    `CHK(n, 0)
    for (int k = 0; k < 4; k++) begin
      a = rnd();
      d = rnd();
      w(5, d);
      op(FSPC_CMD_PROGRAM, a, 1, n);
      `CHK(n, PR + 3)
      `CHK(hold_n, PR + 3)
      `CHK(pump_n, PR + 1)
      `CHK({tah, tal}, a)
      `CHK(cmdr, FSPC_CMD_PROGRAM)
      mem[a] = mdl(a) & d;
      op(FSPC_CMD_READ, a, 1, n);
      `CHK(fdat, mdl(a))
      `CHK(pump_n, 0)
      `CHK(chip[6], 1'b0)
    end
    op(FSPC_CMD_ERASE, a, 1, n);
    `CHK(n, ER + 3)
    `CHK(pump_n, ER + 1)
    for (int k = 0; k < 128; k++) mem[{a[15:7], k[6:0]}] = 8'hff;
    op(FSPC_CMD_READ, a, 1, n);
    `CHK(fdat, mdl(a))
    // The loader block opens once its own update bit is set; the data byte is unchanged.
    w(2, 8'h03);
    `CHK(bue, 8'h03)
    op(FSPC_CMD_PROGRAM | 8'h04, a, 1, n);
    `CHK(n, PR + 3)
    `CHK(cmdr, FSPC_CMD_PROGRAM | 8'h04)
    fail = 1'b1;
    op(FSPC_CMD_PROGRAM, a, 1, n);
    `CHK(n, PR + 3)
    `CHK(chip[6], 1'b1)
    fail = 1'b0;
    d = mdl(a);
    for (int k = 7; k >= 0; k--) q.push_back(d[k]);
    rpin = 1'b0;
    @(negedge sys_clk_i);
    `CHK(in_circuit_programming, 1'b1)
    `CHK(oe_n, 1'b0)
    // Data is set a cycle before each rise, as a programmer would.
    for (int k = 0; k < 16; k++) begin
      v = rnd();
      sda = v[0];
      q.push_back(v[0]);
      @(negedge sys_clk_i);
      sck = 1'b1;
      @(negedge sys_clk_i);
      sck = 1'b0;
      b = q.pop_front();
      `CHK(sdo, b)
    end
    rpin = 1'b1;
    repeat (6) @(negedge sys_clk_i);
    `CHK(in_circuit_programming, 1'b0)
    `CHK(oe_n, 1'b1)
    test_done();
  end
endmodule

// ===== fspc_flash_model.sv
// Behavioural flash array behind the controller's flash port.
// Assumes erase, program and read are levels held for a busy phase.
`timescale 1ns/1ps
module fspc_flash_model (
  input wire logic sys_clk_i,
  input wire logic erase_i,
  input wire logic prog_i,
  input wire logic read_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic fail_i,
  output logic ok_o,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [0:65535];
  logic erase_q = 1'b0;
  logic prog_q = 1'b0;
  initial begin
    foreach (mem[k]) mem[k] = 8'hff;
    rdata_o = 8'h5a;
  end
  assign ok_o = !fail_i;
  always @(posedge sys_clk_i) begin
    erase_q <= erase_i;
    prog_q <= prog_i;
    if (erase_i && !erase_q) begin
      for (int k = 0; k < 128; k++) mem[{addr_i[15:7], k[6:0]}] = 8'hff;
    end
    if (prog_i && !prog_q) mem[addr_i] = mem[addr_i] & wdata_i;
    // Outside a read the bus toggles, so a stale byte never passes for data.
    rdata_o <= read_i ? mem[addr_i] : ~rdata_o;
  end
endmodule

// ===== fspc_pkg.sv
// Package for the flash self-program controller: timing, commands and field positions.
// Assumes a 100 MHz system clock; erase and program counts derive from it.
package fspc_pkg;
  localparam int unsigned FSPC_CLK_MHZ = 100;
  localparam int unsigned FSPC_ERASE_TIME_US = 5000;
  localparam int unsigned FSPC_PROG_TIME_NS = 23500;
  localparam int unsigned FSPC_ERASE_CYCLES = FSPC_ERASE_TIME_US * FSPC_CLK_MHZ;
  localparam int unsigned FSPC_PROG_CYCLES = (FSPC_PROG_TIME_NS * FSPC_CLK_MHZ) / 1000;
  localparam int unsigned FSPC_READ_CYCLES = 2;
  localparam int unsigned FSPC_PAGE_BYTES = 128;
  localparam int unsigned FSPC_PAGE_SHIFT = 7;
  localparam int unsigned FSPC_ENABLE_BIT = 0;
  localparam int unsigned FSPC_FAIL_BIT = 6;
  localparam int unsigned FSPC_TRIG_BIT = 0;
  localparam logic [7:0] FSPC_TA_KEY1 = 8'haa;
  localparam logic [7:0] FSPC_TA_KEY2 = 8'h55;
  localparam logic [1:0] FSPC_TA_WINDOW = 2'h3;
  localparam logic [7:0] FSPC_CMD_READ = 8'h00;
  localparam logic [7:0] FSPC_CMD_PROGRAM = 8'h21;
  localparam logic [7:0] FSPC_CMD_ERASE = 8'h22;
  localparam logic [7:0] FSPC_CMD_BLK_MASK = 8'h0c;
  localparam int unsigned FSPC_CMD_BLK_POS = 2;
  localparam logic [7:0] FSPC_CHIP_CTRL_RST = 8'h00;
  typedef enum logic [1:0] {
    FSPC_BLK_APP,
    FSPC_BLK_LOADER,
    FSPC_BLK_CONFIG,
    FSPC_BLK_NONE
  } fspc_blk_t;
endpackage

// ===== fspc_timer.sv
// Down-counter that times one flash operation.
// Assumes load is a one-cycle pulse and count is nonzero.
`timescale 1ns/1ps
module fspc_timer
  import fspc_pkg::*;
#(
  parameter int unsigned WIDTH = 20
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic load_i,
  input wire logic [WIDTH-1:0] count_i,
  output logic done_o
);
  logic [WIDTH-1:0] cnt_r;
  logic [WIDTH-1:0] cnt_nxt;
  logic run_r;
  logic run_nxt;
  logic done_r;
  logic done_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    run_nxt = run_r;
    done_nxt = 1'b0;
    if (load_i) begin
      cnt_nxt = count_i;
      run_nxt = 1'b1;
    end else if (run_r) begin
      if (cnt_r <= WIDTH'(1)) begin
        run_nxt = 1'b0;
        done_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r - WIDTH'(1);
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_r <= '0;
      run_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      run_r <= run_nxt;
      done_r <= done_nxt;
    end
  end

  assign done_o = done_r;
endmodule
